/* File: verilog/hmb_mailbox.sv */
// Purpose : Host mailbox pair, paged memory access and link activation.
// Assumes : One clock, synchronous active-low reset, inputs synchronous.
// Notes   : Processor registers over classic Wishbone, host over a
//           simple request port answered by a one-cycle acknowledge.
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`include "hmb_consts.svh"

// Functional notes
// - Processor running: host reaches only access control, mailboxes, update flag.
// - Inbound mailbox interrupt asserts only while its enable is 1.
// - Processor writing 1 to inbound status clears the pending interrupt.
// - Update flag shows software refreshed outbound mailbox; host polls it.
// - Mailboxes are 16 bits; wide hosts move both bytes, others one byte at a time.
// - Byte read of outbound low byte captures the high byte in a shadow.
// - Following high byte read returns the shadow, not the live byte.
// - Only a host write of the inbound high byte raises the interrupt.
// - Host writing 1 to the hold bit holds the processor in reset.
// - Host writing 1 to host access enable, with the hold bit also 1, grants direct memory access.
// - Held and enabled, every memory is reachable without software.
// - Paged memories appear as 256-byte pages; low address from host.
// - Upper bits from page registers: 5 for OTP and dev RAM, 2 working.
// - OTP programs 32-bit words via program location; reads use read page.
// - EEPROM writes go in 8-byte groups chosen by the row select.
// - Device never answers on the link unless a host command asks.
// - Activation needs supply low then high, each for the deglitch time.
// - Filter select 0 gives 1 ms, 1 gives 10 ms, resets to 0.
// - Valid activation raises interrupt when enabled; writing 1 clears flag.
// - Link works only with link enable and transceiver connect both 1.
module hmb_mailbox #(
  parameter int unsigned DGL_SHORT_CYC = `HMB_DGL_SHORT_CYC,
  parameter int unsigned DGL_LONG_CYC  = `HMB_DGL_LONG_CYC
) (
  // Clock, reset and enable
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                ce,
  // Processor Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [5:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Host request port
  input  wire logic                host_req,
  input  wire logic                host_we,
  input  wire logic                host_wide,
  input  wire hmb_pkg::hmb_space_t host_space,
  input  wire logic [7:0]          host_addr,
  input  wire logic [15:0]         host_wdata,
  output logic                     host_ack,
  output logic      [15:0]         host_rdata,
  // Memory access port
  output logic                     mem_req,
  output logic                     mem_we,
  output hmb_pkg::hmb_space_t      mem_space,
  output logic      [12:0]         mem_addr,
  output logic      [7:0]          mem_wdata,
  input  wire logic                mem_ack,
  input  wire logic [7:0]          mem_rdata,
  // Supply comparator and link controls
  input  wire logic                supply_above,
  output logic                     link_active,
  output logic                     line_transceiver_connect,
  // Processor side
  output logic                     cpu_hold,
  output logic                     inbound_irq,
  output logic                     activation_irq
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {HMB_H_IDLE, HMB_H_MEM} hmb_hst_t;
  typedef enum logic [1:0] {HMB_A_LOW, HMB_A_HIGH, HMB_A_DONE} hmb_act_t;

  hmb_hst_t    hst_r;
  hmb_act_t    act_r;
  logic [15:0] outbound_mailbox_r;
  logic [15:0] inbound_mailbox_r;
  logic [7:0]  shadow_r;
  logic        out_updated_r;
  logic        in_pend_r;
  logic        inbound_irq_enable_r;
  logic        act_flag_r;
  logic        activation_irq_enable_r;
  logic [1:0]  pac_r;
  logic [2:0]  host_port_control_r;
  logic [4:0]  otp_page_r;
  logic [7:0]  otp_program_location_r;
  logic [4:0]  dev_ram_page_r;
  logic [1:0]  working_ram_page_r;
  logic [3:0]  ee_row_r;
  logic [23:0] dgl_cnt_r;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  logic        wb_hit;
  logic        wb_wr;
  logic        h_ctrl;
  logic        h_rd_lo;
  logic        h_rd_hi;
  logic        h_wr_in;
  logic        h_wr_hi;
  logic        h_pac_wr;
  logic        h_open;
  logic        h_cfg_wr;
  logic        h_mem;
  logic        cpu_hi_wr;
  logic [23:0] dgl_lim;

  assign wb_hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr    = wb_hit && wb_we_i;
  assign cpu_hi_wr = wb_wr && wb_adr_i == `HMB_W_OUTBOX && wb_sel_i[1];
  assign h_open   = pac_r[`HMB_PAC_HOLD] && pac_r[`HMB_PAC_HOST_EN];
  assign h_ctrl   = ce && host_req && hst_r == HMB_H_IDLE &&
                    host_space == hmb_pkg::HMB_SP_CTRL;
  assign h_rd_lo  = h_ctrl && !host_we && host_addr == `HMB_H_OUT_LO;
  assign h_rd_hi  = h_ctrl && !host_we &&
                    ((host_addr == `HMB_H_OUT_HI && !host_wide) ||
                     (host_addr == `HMB_H_OUT_LO && host_wide));
  assign h_wr_in  = h_ctrl && host_we && host_addr == `HMB_H_IN_LO;
  assign h_wr_hi  = h_ctrl && host_we &&
                    ((host_addr == `HMB_H_IN_HI && !host_wide) ||
                     (host_addr == `HMB_H_IN_LO && host_wide));
  assign h_pac_wr = h_ctrl && host_we && host_addr == `HMB_H_PAC;
  assign h_cfg_wr = h_ctrl && host_we && pac_r[`HMB_PAC_HOLD];
  assign h_mem    = ce && host_req && hst_r == HMB_H_IDLE && h_open &&
                    host_space != hmb_pkg::HMB_SP_CTRL;
  assign dgl_lim  = host_port_control_r[`HMB_PCTL_FILTER] ?
                    DGL_LONG_CYC[23:0] : DGL_SHORT_CYC[23:0];

  // --------------------------------------------------------------------
  // Processor Wishbone slave
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce) begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          `HMB_W_INBOX:    wb_dat_o <= {16'h0, inbound_mailbox_r};
          `HMB_W_OUTBOX:   wb_dat_o <= {16'h0, outbound_mailbox_r};
          `HMB_W_IN_IEN:   wb_dat_o <= {31'h0, inbound_irq_enable_r};
          `HMB_W_IN_STAT:  wb_dat_o <= {31'h0, in_pend_r};
          `HMB_W_ACT_IEN:  wb_dat_o <= {31'h0, activation_irq_enable_r};
          `HMB_W_ACT_FLAG: wb_dat_o <= {31'h0, act_flag_r};
          `HMB_W_PORT_CTL: wb_dat_o <= {29'h0, host_port_control_r};
          `HMB_W_STATUS:   wb_dat_o <= {28'h0, in_pend_r, pac_r,
                                        out_updated_r};
          default:         wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Processor-written control registers
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      outbound_mailbox_r      <= 16'h0;
      inbound_irq_enable_r    <= 1'b0;
      activation_irq_enable_r <= 1'b0;
      host_port_control_r     <= `HMB_RST_PCTL;
    end else if (ce && wb_wr) begin
      if (wb_adr_i == `HMB_W_OUTBOX) begin
        if (wb_sel_i[0]) begin
          outbound_mailbox_r[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          outbound_mailbox_r[15:8] <= wb_dat_i[15:8];
        end
      end
      if (wb_adr_i == `HMB_W_IN_IEN && wb_sel_i[0]) begin
        inbound_irq_enable_r <= wb_dat_i[0];
      end
      if (wb_adr_i == `HMB_W_ACT_IEN && wb_sel_i[0]) begin
        activation_irq_enable_r <= wb_dat_i[0];
      end
      if (wb_adr_i == `HMB_W_PORT_CTL && wb_sel_i[0]) begin
        host_port_control_r <= wb_dat_i[2:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Outbound update flag and shadow byte
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      out_updated_r <= 1'b0;
      shadow_r      <= 8'h0;
    end else if (ce) begin
      if (cpu_hi_wr) begin
        out_updated_r <= 1'b1;
      end else if (h_rd_hi) begin
        out_updated_r <= 1'b0;
      end
      if (h_rd_lo && !host_wide) begin
        shadow_r <= outbound_mailbox_r[15:8];
      end
    end
  end

  // --------------------------------------------------------------------
  // Inbound mailbox and its interrupt
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      inbound_mailbox_r <= 16'h0;
      in_pend_r         <= 1'b0;
    end else if (ce) begin
      if (h_wr_in) begin
        inbound_mailbox_r[7:0] <= host_wdata[7:0];
      end
      if (h_wr_hi) begin
        inbound_mailbox_r[15:8] <= host_wide ? host_wdata[15:8]
                                             : host_wdata[7:0];
      end
      // A new high byte in the clearing cycle keeps the flag set.
      if (h_wr_hi) begin
        in_pend_r <= 1'b1;
      end else if (wb_wr && wb_adr_i == `HMB_W_IN_STAT &&
                   wb_sel_i[0] && wb_dat_i[0]) begin
        in_pend_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Host-written access control and page registers
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pac_r                  <= `HMB_RST_PAC;
      otp_page_r             <= 5'h0;
      otp_program_location_r <= 8'h0;
      dev_ram_page_r         <= 5'h0;
      working_ram_page_r     <= 2'h0;
      ee_row_r               <= 4'h0;
    end else if (ce) begin
      if (h_pac_wr) begin
        pac_r <= host_wdata[1:0];
      end
      if (h_cfg_wr) begin
        unique case (host_addr)
          `HMB_H_OTP_PAGE: otp_page_r <= host_wdata[4:0];
          `HMB_H_OTP_PROG: otp_program_location_r <= host_wdata[7:0];
          `HMB_H_DEV_PAGE: dev_ram_page_r <= host_wdata[4:0];
          `HMB_H_WRK_PAGE: working_ram_page_r <= host_wdata[1:0];
          `HMB_H_EE_ROW:   ee_row_r <= host_wdata[3:0];
          default:         ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Host answer and memory sequencing
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hst_r      <= HMB_H_IDLE;
      host_ack   <= 1'b0;
      host_rdata <= 16'h0;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_space  <= hmb_pkg::HMB_SP_CTRL;
      mem_addr   <= 13'h0;
      mem_wdata  <= 8'h0;
    end else if (ce) begin
      host_ack <= 1'b0;
      mem_req  <= 1'b0;
      unique case (hst_r)
        HMB_H_IDLE: begin
          if (h_mem) begin
            hst_r     <= HMB_H_MEM;
            mem_req   <= 1'b1;
            mem_we    <= host_we;
            mem_space <= host_space;
            mem_wdata <= host_wdata[7:0];
            unique case (host_space)
              hmb_pkg::HMB_SP_WORK:
                mem_addr <= {3'h0, working_ram_page_r, host_addr};
              hmb_pkg::HMB_SP_DEV:
                mem_addr <= {dev_ram_page_r, host_addr};
              hmb_pkg::HMB_SP_OTP:
                mem_addr <= host_we ?
                  {3'h0, otp_program_location_r, host_addr[1:0]} :
                  {otp_page_r, host_addr};
              hmb_pkg::HMB_SP_EEPROM:
                mem_addr <= host_we ?
                  {6'h0, ee_row_r, host_addr[2:0]} :
                  {6'h0, host_addr[6:0]};
              default: mem_addr <= {5'h0, host_addr};
            endcase
          end else if (ce && host_req) begin
            // A command taken in idle gets one answer; one arriving during a memory access gets none.
            host_ack   <= 1'b1;
            host_rdata <= 16'h0;
            if (!host_we && host_space == hmb_pkg::HMB_SP_CTRL) begin
              unique case (host_addr)
                `HMB_H_OUT_LO: host_rdata <= host_wide ?
                  outbound_mailbox_r :
                  {8'h0, outbound_mailbox_r[7:0]};
                `HMB_H_OUT_HI: host_rdata <= {8'h0, shadow_r};
                `HMB_H_TXFLAG: host_rdata <= {15'h0, out_updated_r};
                `HMB_H_PAC:    host_rdata <= {14'h0, pac_r};
                default:       host_rdata <= 16'h0;
              endcase
            end
          end
        end
        HMB_H_MEM: begin
          if (mem_ack) begin
            hst_r      <= HMB_H_IDLE;
            host_ack   <= 1'b1;
            host_rdata <= {8'h0, mem_rdata};
          end
        end
        default: hst_r <= HMB_H_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Activation pulse deglitch
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      act_r     <= HMB_A_LOW;
      dgl_cnt_r <= 24'h0;
    end else if (ce) begin
      unique case (act_r)
        HMB_A_LOW: begin
          if (supply_above) begin
            dgl_cnt_r <= 24'h0;
          end else if (dgl_cnt_r >= dgl_lim - 24'h1) begin
            act_r     <= HMB_A_HIGH;
            dgl_cnt_r <= 24'h0;
          end else begin
            dgl_cnt_r <= dgl_cnt_r + 24'h1;
          end
        end
        HMB_A_HIGH: begin
          if (!supply_above && dgl_cnt_r == 24'h0) begin
            // A low phase longer than the filter time just waits here.
            dgl_cnt_r <= 24'h0;
          end else if (!supply_above) begin
            // A dip restarts the low phase from the dip itself.
            act_r     <= HMB_A_LOW;
            dgl_cnt_r <= 24'h1;
          end else if (dgl_cnt_r >= dgl_lim - 24'h1) begin
            act_r     <= HMB_A_DONE;
            dgl_cnt_r <= 24'h0;
          end else begin
            dgl_cnt_r <= dgl_cnt_r + 24'h1;
          end
        end
        HMB_A_DONE: begin
          act_r     <= HMB_A_LOW;
          dgl_cnt_r <= 24'h0;
        end
        default: act_r <= HMB_A_LOW;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Activation flag and processor outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      act_flag_r               <= 1'b0;
      inbound_irq              <= 1'b0;
      activation_irq           <= 1'b0;
      cpu_hold                 <= 1'b0;
      link_active              <= 1'b0;
      line_transceiver_connect <= 1'b0;
    end else if (ce) begin
      if (act_r == HMB_A_DONE) begin
        act_flag_r <= 1'b1;
      end else if (wb_wr && wb_adr_i == `HMB_W_ACT_FLAG &&
                   wb_sel_i[0] && wb_dat_i[0]) begin
        act_flag_r <= 1'b0;
      end
      inbound_irq    <= in_pend_r && inbound_irq_enable_r;
      activation_irq <= act_flag_r && activation_irq_enable_r;
      cpu_hold       <= pac_r[`HMB_PAC_HOLD];
      link_active    <= host_port_control_r[`HMB_PCTL_LINK_ON] &&
                        host_port_control_r[`HMB_PCTL_CONNECT];
      line_transceiver_connect <=
        host_port_control_r[`HMB_PCTL_CONNECT];
    end
  end

endmodule // hmb_mailbox

/* File: verilog/hmb_consts.svh */
// Purpose : Offsets, field positions, reset values and timing counts.
// Assumes : Included by the host mailbox block and its bench.
// Notes   : Definitions only.
`ifndef HMB_CONSTS_SVH
`define HMB_CONSTS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HMB_CLK_MHZ          250
`define HMB_DGL_SHORT_US     1000
`define HMB_DGL_LONG_US      10000
`define HMB_DGL_SHORT_CYC    (`HMB_DGL_SHORT_US * `HMB_CLK_MHZ)
`define HMB_DGL_LONG_CYC     (`HMB_DGL_LONG_US * `HMB_CLK_MHZ)

// ----------------------------------------------------------------------
// Host control page offsets (8-bit host address)
// ----------------------------------------------------------------------
`define HMB_H_OUT_LO         8'h00
`define HMB_H_OUT_HI         8'h01
`define HMB_H_IN_LO          8'h02
`define HMB_H_IN_HI          8'h03
`define HMB_H_TXFLAG         8'h04
`define HMB_H_PAC            8'h0C
`define HMB_H_OTP_PAGE       8'h10
`define HMB_H_OTP_PROG       8'h11
`define HMB_H_DEV_PAGE       8'h12
`define HMB_H_WRK_PAGE       8'h13
`define HMB_H_EE_ROW         8'h14

// ----------------------------------------------------------------------
// Processor Wishbone byte offsets
// ----------------------------------------------------------------------
`define HMB_W_INBOX          6'h00
`define HMB_W_OUTBOX         6'h04
`define HMB_W_IN_IEN         6'h08
`define HMB_W_IN_STAT        6'h0C
`define HMB_W_ACT_IEN        6'h10
`define HMB_W_ACT_FLAG       6'h14
`define HMB_W_PORT_CTL       6'h18
`define HMB_W_STATUS         6'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HMB_PAC_HOLD         0
`define HMB_PAC_HOST_EN      1
`define HMB_PCTL_LINK_ON     0
`define HMB_PCTL_CONNECT     1
`define HMB_PCTL_FILTER      2
`define HMB_ST_TXFLAG        0
`define HMB_ST_HOLD          1
`define HMB_ST_HOST_EN       2
`define HMB_ST_IN_PEND       3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HMB_RST_PAC          2'h0
`define HMB_RST_PCTL         3'h0

`endif

/* File: verilog/hmb_pkg.sv */
// Purpose : Types shared by the host mailbox block and its bench.
// Assumes : Nothing beyond SystemVerilog packages.
// Notes   : Constants live in hmb_consts.svh.
package hmb_pkg;

  // --------------------------------------------------------------------
  // Host address spaces
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    HMB_SP_CTRL    = 3'h0,
    HMB_SP_WORK    = 3'h1,
    HMB_SP_DEV     = 3'h3,
    HMB_SP_OTP     = 3'h4,
    HMB_SP_EEPROM  = 3'h5
  } hmb_space_t;

endpackage

/* File: tb/hmb_mailbox_chk.sv */
// Purpose : Port-level checks on the host mailbox block.
// Assumes : Bound into hmb_mailbox with the bench's deglitch count.
// Notes   : The ce input is held high by the bench.
`timescale 1ns/10ps
`include "hmb_consts.svh"
module hmb_mailbox_chk #(
  parameter int unsigned DGL_SHORT_CYC = 8
) (
  // Clock, reset and processor bus
  input wire logic        clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  // Host, memory, link and processor lines
  input wire logic        host_ack, mem_req, mem_ack, supply_above,
  input wire logic        link_active, line_transceiver_connect,
  input wire logic        cpu_hold, inbound_irq, activation_irq
);
  logic [15:0] high_cnt_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Saturates so that a long quiet supply cannot wrap to a small count.
  always_ff @(posedge clock) begin
    if (!rstn || !supply_above) high_cnt_r <= 16'h0000;
    else if (high_cnt_r != 16'hFFFF) high_cnt_r <= high_cnt_r + 16'h0001;
  end
  sequence wb_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence stat_clear;
    wb_take ##1 (wb_ack_o && wb_we_i && wb_adr_i == `HMB_W_IN_STAT
                 && wb_dat_i[0]);
  endsequence
  wb_answer_a: assert property (wb_take |=> wb_ack_o)
    else $error("bus request not answered");
  wb_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  host_pulse_a: assert property (host_ack |=> !host_ack)
    else $error("host ack longer than one cycle");
  mem_held_a: assert property (mem_req |-> cpu_hold)
    else $error("memory reached while processor runs");
  mem_answer_a: assert property (mem_ack |=> host_ack)
    else $error("memory answer not passed to host");
  link_pair_a: assert property (link_active |-> line_transceiver_connect)
    else $error("link active without connect");
  act_filter_a: assert property ($rose(activation_irq) |->
    high_cnt_r >= DGL_SHORT_CYC) else $error("activation too early");
  in_clear_a: assert property (stat_clear |=> !inbound_irq)
    else $error("inbound irq not cleared");
endmodule // hmb_mailbox_chk
bind hmb_mailbox hmb_mailbox_chk #(.DGL_SHORT_CYC(DGL_SHORT_CYC)) chk (.*);

/* File: tb/hmb_mem_model.sv */
// Purpose : Memory behind the paged host port, answering slowly.
// Assumes : One request at a time, address held until the answer.
// Notes   : Read data is the low address XOR A5; idle data toggles.
`timescale 1ns/10ps
module hmb_mem_model (
  // Clock, reset and memory port
  input  wire logic        clock, rstn, mem_req,
  input  wire logic [12:0] mem_addr,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata
);
  logic [1:0] wait_r;
  // Toggling idle data keeps a stale byte from passing for a real answer.
  always_ff @(posedge clock) begin
    mem_ack <= rstn && wait_r == 2'h1;
    mem_rdata <= (wait_r == 2'h1) ? mem_addr[7:0] ^ 8'hA5 : ~mem_rdata;
    if (!rstn) wait_r <= 2'h0;
    else if (mem_req) wait_r <= 2'h3;
    else if (wait_r != 2'h0) wait_r <= wait_r - 2'h1;
  end
endmodule // hmb_mem_model

/* File: tb/hmb_mailbox_bench.sv */
// Purpose : Self-checking bench for the host mailbox block.
// Assumes : Deglitch counts shortened to 8 and 20 cycles.
// Notes   : Bus and host tasks wait for the answer under a bound.
`timescale 1ns/10ps
`include "hmb_consts.svh"
module hmb_mailbox_bench;
  localparam hmb_pkg::hmb_space_t CT = hmb_pkg::HMB_SP_CTRL;
  logic clock = 1'b0, rstn = 1'b0, wb_go = 1'b0, wb_we = 1'b0;
  logic host_req = 1'b0, host_we = 1'b0, host_wide = 1'b0;
  logic supply_above = 1'b1, wb_ack, host_ack, mem_req, mem_we, mem_ack;
  logic link_active, line_transceiver_connect, cpu_hold, seen_we;
  logic inbound_irq, activation_irq;
  logic [5:0]  wb_adr = 6'h00;
  logic [7:0]  host_addr = 8'h00, mem_wdata, mem_rdata, seen_wd;
  logic [12:0] mem_addr, seen_addr;
  logic [15:0] host_wdata = 16'h0000, host_rdata, hq;
  logic [31:0] wb_wd = 32'h0, wb_rd, wq;
  hmb_pkg::hmb_space_t host_space = CT;
  int errors = 0, tests_run = 0;
  hmb_mailbox #(.DGL_SHORT_CYC(8), .DGL_LONG_CYC(20)) dut (.clock, .rstn,
    .ce(1'b1), .wb_cyc_i(wb_go), .wb_stb_i(wb_go), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'h3), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack), .host_req, .host_we, .host_wide, .host_space,
    .host_addr, .host_wdata, .host_ack, .host_rdata, .mem_req, .mem_we,
    .mem_space(), .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .supply_above,
    .link_active, .line_transceiver_connect, .cpu_hold, .inbound_irq,
    .activation_irq);
  hmb_mem_model mem (.clock, .rstn, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata);
  always #2 clock = ~clock;
  always @(posedge clock) if (mem_req === 1'b1) begin
    seen_addr <= mem_addr;
    seen_we <= mem_we;
    seen_wd <= mem_wdata;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    {wb_go, wb_we, wb_adr, wb_wd} <= {1'b1, we, a, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    wq = wb_rd;
    wb_go <= 1'b0;
    if (n >= 50) chk("bus ack", 32'h1, 32'h0);
  endtask
  task automatic host(input logic we, wide, input hmb_pkg::hmb_space_t sp,
                      input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clock);
    {host_req, host_we, host_wide} <= {1'b1, we, wide};
    host_space <= sp;
    {host_addr, host_wdata} <= {a, d};
    @(posedge clock);
    host_req <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (host_ack !== 1'b1 && n < 50);
    hq = host_rdata;
    if (n >= 50) chk("host ack", 32'h1, 32'h0);
  endtask
  task automatic t_outbox();
    wb(1'b0, `HMB_W_STATUS, 32'h0);
    chk("status reset", 32'h0, wq);
    wb(1'b0, 6'h20, 32'h0);
    chk("unmapped", 32'h0, wq);
    wb(1'b1, `HMB_W_OUTBOX, 32'h1234);
    host(1'b0, 1'b0, CT, `HMB_H_TXFLAG, 16'h0);
    chk("update flag", 32'h1, 32'(hq[0]));
    host(1'b0, 1'b0, CT, `HMB_H_OUT_LO, 16'h0);
    chk("outbox low", 32'h34, 32'(hq[7:0]));
    wb(1'b1, `HMB_W_OUTBOX, 32'hABCD);
    host(1'b0, 1'b0, CT, `HMB_H_OUT_HI, 16'h0);
    chk("shadow byte", 32'h12, 32'(hq[7:0]));
    host(1'b0, 1'b0, CT, `HMB_H_TXFLAG, 16'h0);
    chk("flag clear", 32'h0, 32'(hq[0]));
    host(1'b0, 1'b1, CT, `HMB_H_OUT_LO, 16'h0);
    chk("wide read", 32'hABCD, 32'(hq));
    $display("test outbox done");
  endtask
  task automatic t_inbox();
    host(1'b1, 1'b0, CT, `HMB_H_IN_LO, 16'h0055);
    repeat (3) @(posedge clock);
    chk("irq low byte", 32'h0, 32'(inbound_irq));
    host(1'b1, 1'b0, CT, `HMB_H_IN_HI, 16'h00AA);
    repeat (3) @(posedge clock);
    chk("irq masked", 32'h0, 32'(inbound_irq));
    wb(1'b1, `HMB_W_IN_IEN, 32'h1);
    repeat (3) @(posedge clock);
    chk("irq raised", 32'h1, 32'(inbound_irq));
    wb(1'b0, `HMB_W_INBOX, 32'h0);
    chk("inbox word", 32'hAA55, wq);
    wb(1'b1, `HMB_W_IN_STAT, 32'h1);
    repeat (3) @(posedge clock);
    chk("irq cleared", 32'h0, 32'(inbound_irq));
    $display("test inbox done");
  endtask
  task automatic t_paged();
    host(1'b0, 1'b0, hmb_pkg::HMB_SP_WORK, 8'h3C, 16'h0);
    chk("running access", 32'h0, 32'(hq));
    host(1'b1, 1'b0, CT, `HMB_H_PAC, 16'h0003);
    @(posedge clock);
    chk("hold", 32'h1, 32'(cpu_hold));
    wb(1'b0, `HMB_W_STATUS, 32'h0);
    chk("host enable", 32'h1, 32'(wq[`HMB_ST_HOST_EN]));
    host(1'b1, 1'b0, CT, `HMB_H_WRK_PAGE, 16'h0002);
    host(1'b0, 1'b0, hmb_pkg::HMB_SP_WORK, 8'h3C, 16'h0);
    chk("work data", 32'h99, 32'(hq[7:0]));
    chk("work addr", 32'h023C, 32'(seen_addr));
    host(1'b1, 1'b0, CT, `HMB_H_DEV_PAGE, 16'h001F);
    host(1'b1, 1'b0, hmb_pkg::HMB_SP_DEV, 8'h80, 16'h005A);
    chk("dev write", 32'h3F805A, {10'h0, seen_we, seen_addr, seen_wd});
    host(1'b1, 1'b0, CT, `HMB_H_OTP_PROG, 16'h00A7);
    host(1'b1, 1'b0, hmb_pkg::HMB_SP_OTP, 8'h02, 16'h0011);
    chk("otp", 32'h229E11, {10'h0, seen_we, seen_addr, seen_wd});
    host(1'b1, 1'b0, CT, `HMB_H_PAC, 16'h0000);
    $display("test paged done");
  endtask
  task automatic pulse(input int lo, hi);
    supply_above <= 1'b0;
    repeat (lo) @(posedge clock);
    supply_above <= 1'b1;
    repeat (hi + 3) @(posedge clock);
  endtask
  task automatic t_link();
    wb(1'b1, `HMB_W_ACT_IEN, 32'h1);
    pulse(4, 12);
    chk("glitch", 32'h0, 32'(activation_irq));
    pulse(10, 10);
    chk("activation", 32'h1, 32'(activation_irq));
    wb(1'b1, `HMB_W_ACT_FLAG, 32'h1);
    repeat (3) @(posedge clock);
    chk("act cleared", 32'h0, 32'(activation_irq));
    wb(1'b1, `HMB_W_PORT_CTL, 32'h5);
    pulse(10, 10);
    chk("long filter", 32'h0, 32'(activation_irq));
    chk("link half", 32'h0, 32'(link_active));
    pulse(22, 22);
    chk("long pass", 32'h1, 32'(activation_irq));
    wb(1'b1, `HMB_W_PORT_CTL, 32'h7);
    @(posedge clock);
    chk("link on", 32'h3, 32'({link_active, line_transceiver_connect}));
    $display("test link done");
  endtask
  initial begin
    #80000;
    errors++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    t_outbox();
    t_inbox();
    t_paged();
    t_link();
    end_sim();
  end
endmodule // hmb_mailbox_bench
